// File: logic/pfrs_pkg.sv
// types of the flag and reset-cause block
// assumes the constants header is on the include path
package pfrs_pkg;
`include "pfrs_regs.svh"
  typedef logic [7:0] pfrs_byte_type;
  typedef logic [1:0] pfrs_resp_type;
  typedef enum logic [1:0] {PFRS_RSP_OKAY = 2'h0, PFRS_RSP_SLVERR = 2'h2} pfrs_rsp_type;
endpackage : pfrs_pkg

// File: logic/pfrs_regs.svh
// register offsets, field positions, reset values of the flag and reset-cause block
// assumes inclusion by bare name from the package and the design files
`ifndef PFRS_REGS_SVH
`define PFRS_REGS_SVH
`define PFRS_IDX_REQ 8'h0D
`define PFRS_IDX_PWR 8'h8E
`define PFRS_ADDR_REQ 12'h034
`define PFRS_ADDR_PWR 12'h238
`define PFRS_ADDR_MASK 12'h400
`define PFRS_ADDR_IRQST 12'h404
`define PFRS_ADDR_CFG 12'h408
`define PFRS_BIT_OSF 7
`define PFRS_BIT_CMP2 6
`define PFRS_BIT_CMP1 5
`define PFRS_BIT_NVW 4
`define PFRS_BIT_ULPW 5
`define PFRS_BIT_SBOR 4
`define PFRS_BIT_POR 1
`define PFRS_BIT_BOR 0
`define PFRS_REQ_IMPL 8'hF0
`define PFRS_PWR_IMPL 8'h33
`define PFRS_PWR_RESET 8'h10
`define PFRS_BOR_SOFT_MODE 2'h1
`define PFRS_NUM_EVT 6
`endif

// File: logic/pfrs_sync.sv
// three-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk_i
`timescale 1ns/10ps
module pfrs_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change taken once the later two stages agree
      if (s2_q == s3_q)
      begin
        level_o <= s3_q;
      end
    end
  end
endmodule : pfrs_sync

// File: logic/pfrs_top.sv
// request flags and power control / reset cause registers behind AXI4-Lite
// assumes event sources are asynchronous pins; cpu reaches registers over AXI4-Lite
`timescale 1ns/10ps
`include "pfrs_regs.svh"
module pfrs_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output pfrs_pkg::pfrs_resp_type s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output pfrs_pkg::pfrs_resp_type s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_fail_i,
  input wire logic cmp_one_output_i,
  input wire logic cmp_two_output_i,
  input wire logic nv_write_busy_i,
  input wire logic por_event_i,
  input wire logic bor_event_i,
  input wire logic wdt_event_i,
  input wire logic pin_reset_event_i,
  input wire logic [1:0] brownout_config_mode_i,
  output logic ultra_low_power_wake_en_o,
  output logic brownout_detect_en_o,
  output logic irq_o
);
  import pfrs_pkg::*;

  // event pins plus watchdog and pin-reset causes
  localparam int NS = `PFRS_NUM_EVT + 2;
  logic [NS-1:0] raw;
  logic [NS-1:0] lvl;
  logic [NS-1:0] lvl_q;
  logic osf_ev;
  logic cmp1_ev;
  logic cmp2_ev;
  logic nvw_ev;
  logic por_ev;
  logic bor_ev;
  logic wdt_ev;
  logic pin_ev;

  assign raw = {pin_reset_event_i, wdt_event_i, bor_event_i, por_event_i, nv_write_busy_i,
                cmp_two_output_i, cmp_one_output_i, osc_fail_i};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_sync
      pfrs_sync u_sync
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(raw[gi]),
        .level_o(lvl[gi])
      );
    end
  endgenerate

  // edge history of the synchronised levels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lvl_q <= '0;
    end
    else
    begin
      lvl_q <= lvl;
    end
  end

  assign osf_ev = lvl[0] & ~lvl_q[0];
  assign cmp1_ev = lvl[1] ^ lvl_q[1];
  assign cmp2_ev = lvl[2] ^ lvl_q[2];
  assign nvw_ev = ~lvl[3] & lvl_q[3];
  assign por_ev = lvl[4] & ~lvl_q[4];
  assign bor_ev = lvl[5] & ~lvl_q[5];
  assign wdt_ev = lvl[6] & ~lvl_q[6];
  assign pin_ev = lvl[7] & ~lvl_q[7];

  // ---------------- AXI4-Lite slave
  logic aw_q;
  logic w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;
  logic rd_do;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;
  logic req_wr;
  logic pwr_wr;
  logic mask_wr;
  logic cfg_wr;
  logic irqst_rd_clr;

  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_do = aw_q & w_q & ~s_axi_bvalid;
  assign rd_do = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_do)
      begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_do)
      begin
        w_q <= 1'b0;
      end
    end
  end

  assign wr_hit = (awaddr_q & 12'hFFC) inside {`PFRS_ADDR_REQ, `PFRS_ADDR_PWR, `PFRS_ADDR_MASK,
                                               `PFRS_ADDR_IRQST, `PFRS_ADDR_CFG};

  // only byte lane 0 carries register data
  assign req_wr = wr_do & wstrb_q[0] & ((awaddr_q & 12'hFFC) == `PFRS_ADDR_REQ);
  assign pwr_wr = wr_do & wstrb_q[0] & ((awaddr_q & 12'hFFC) == `PFRS_ADDR_PWR);
  assign mask_wr = wr_do & wstrb_q[0] & ((awaddr_q & 12'hFFC) == `PFRS_ADDR_MASK);
  assign cfg_wr = wr_do & wstrb_q[0] & ((awaddr_q & 12'hFFC) == `PFRS_ADDR_CFG);
  assign irqst_rd_clr = rd_do & ((s_axi_araddr & 12'hFFC) == `PFRS_ADDR_IRQST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PFRS_RSP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? PFRS_RSP_OKAY : PFRS_RSP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- register state
  pfrs_byte_type req_q;
  pfrs_byte_type pwr_q;
  logic [7:0] mask_q;
  logic [7:0] irqst_q;
  logic [3:0] cause_q;
  logic [7:0] wd;
  logic [7:0] evt;

  assign wd = wdata_q[7:0];

  // request flags: hardware set beats software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_q <= 8'h00;
    end
    else
    begin
      if (req_wr)
      begin
        req_q <= wd & `PFRS_REQ_IMPL;
      end
      // set regardless of any enable
      if (osf_ev)
      begin
        req_q[`PFRS_BIT_OSF] <= 1'b1;
      end
      if (cmp2_ev)
      begin
        req_q[`PFRS_BIT_CMP2] <= 1'b1;
      end
      if (cmp1_ev)
      begin
        req_q[`PFRS_BIT_CMP1] <= 1'b1;
      end
      if (nvw_ev)
      begin
        req_q[`PFRS_BIT_NVW] <= 1'b1;
      end
    end
  end

  // power control: POR clears the POR, BOR and ULPW bits, BOR clears its own bit, events win over writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_q <= `PFRS_PWR_RESET;
    end
    else
    begin
      if (pwr_wr)
      begin
        pwr_q <= wd & `PFRS_PWR_IMPL;
      end
      if (por_ev)
      begin
        pwr_q[`PFRS_BIT_POR] <= 1'b0;
        pwr_q[`PFRS_BIT_BOR] <= 1'b0;
        pwr_q[`PFRS_BIT_ULPW] <= 1'b0;
      end
      else if (bor_ev)
      begin
        pwr_q[`PFRS_BIT_BOR] <= 1'b0;
      end
    end
  end

  // watchdog and pin causes, sticky, cleared by software write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_q <= 4'h0;
    end
    else
    begin
      if (cfg_wr)
      begin
        cause_q <= cause_q & ~wd[3:0];
      end
      if (wdt_ev)
      begin
        cause_q[0] <= 1'b1;
      end
      if (pin_ev)
      begin
        cause_q[1] <= 1'b1;
      end
    end
  end

  assign ultra_low_power_wake_en_o = pwr_q[`PFRS_BIT_ULPW];
  // soft enable only counts in mode 01, other modes leave detection as configured
  assign brownout_detect_en_o = (brownout_config_mode_i == `PFRS_BOR_SOFT_MODE) ?
                                pwr_q[`PFRS_BIT_SBOR] : brownout_config_mode_i[1];

  // ---------------- interrupt status, mask, output
  assign evt = {osf_ev, cmp2_ev, cmp1_ev, nvw_ev, por_ev, bor_ev, wdt_ev, pin_ev};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= 8'h00;
    end
    else if (mask_wr)
    begin
      mask_q <= wd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irqst_q <= 8'h00;
    end
    else
    begin
      irqst_q <= (irqst_rd_clr ? 8'h00 : irqst_q) | evt;
    end
  end

  assign irq_o = |(irqst_q & mask_q);

  // ---------------- read channel
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    unique case (s_axi_araddr & 12'hFFC)
      `PFRS_ADDR_REQ:
        rd_val = {24'h000000, req_q & `PFRS_REQ_IMPL};
      `PFRS_ADDR_PWR:
        rd_val = {24'h000000, pwr_q & `PFRS_PWR_IMPL};
      `PFRS_ADDR_MASK:
        rd_val = {24'h000000, mask_q};
      `PFRS_ADDR_IRQST:
        rd_val = {24'h000000, irqst_q};
      `PFRS_ADDR_CFG:
        rd_val = {28'h0000000, cause_q};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= PFRS_RSP_OKAY;
    end
    else if (rd_do)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? PFRS_RSP_OKAY : PFRS_RSP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pfrs_top

// File: tb/pfrs_chk.sv
// port assertions for the flag and reset-cause block
// assumes it is bound onto pfrs_top
`timescale 1ns/10ps
module pfrs_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire pfrs_pkg::pfrs_resp_type s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_event_i,
  input wire logic [1:0] brownout_config_mode_i,
  input wire logic ultra_low_power_wake_en_o,
  input wire logic brownout_detect_en_o,
  input wire logic irq_o
);
  import pfrs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rst_clear_a: assert property ($fell(rst_i) |-> !ultra_low_power_wake_en_o && !irq_o)
    else $error("ulp or irq after reset");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper bits set");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("resp dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while resp");
  bod_mode_a: assert property (brownout_config_mode_i != 2'h1 |->
    brownout_detect_en_o == brownout_config_mode_i[1])
    else $error("detect wrong");
  por_clr_a: assert property ($rose(por_event_i) |-> ##[1:8] !ultra_low_power_wake_en_o)
    else $error("ulp kept");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property ($rose(irq_o));
  cover property ($fell(ultra_low_power_wake_en_o));
endmodule : pfrs_chk

bind pfrs_top pfrs_chk pfrs_chk_i (.*);

// File: tb/tb.sv
// self-checking bench for the flag and reset-cause block
// assumes pfrs_top and its package are compiled first
`timescale 1ns/10ps
`include "pfrs_regs.svh"
module tb;
  import pfrs_pkg::*;
  localparam logic [11:0] a_req = `PFRS_ADDR_REQ;
  localparam logic [11:0] a_pwr = `PFRS_ADDR_PWR;
  localparam logic [11:0] a_msk = `PFRS_ADDR_MASK;
  localparam logic [11:0] a_irq = `PFRS_ADDR_IRQST;
  localparam logic [11:0] a_cau = `PFRS_ADDR_CFG;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  pfrs_resp_type s_axi_bresp, s_axi_rresp, rsp_q;
  logic osc_fail_i = 1'b0, cmp_one_output_i = 1'b0, cmp_two_output_i = 1'b0;
  logic nv_write_busy_i = 1'b0, por_event_i = 1'b0, bor_event_i = 1'b0;
  logic wdt_event_i = 1'b0, pin_reset_event_i = 1'b0;
  logic [1:0] brownout_config_mode_i = 2'h0;
  logic ultra_low_power_wake_en_o, brownout_detect_en_o, irq_o;
  int num_errors = 0;
  int num_checks = 0;

  always #2.5 clk_i = ~clk_i;

  pfrs_top pfrs_top_i (.*);

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic tmo(input logic ok);
    if (!ok)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask : tmo

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc

  // ready raised late so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b && n < 40)
    begin
      @(negedge clk_i);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      rsp_q = s_axi_bresp;
      @(posedge clk_i);
      n++;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= n > 2 && !b;
    end
    tmo(b);
    chk("bresp", rsp_q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    logic ar, r;
    n = 0;
    r = 1'b0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r && n < 40)
    begin
      @(negedge clk_i);
      ar = s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      rd_q = s_axi_rdata;
      rsp_q = s_axi_rresp;
      @(posedge clk_i);
      n++;
      if (ar) s_axi_arvalid <= 1'b0;
      s_axi_rready <= n > 2 && !r;
    end
    tmo(r);
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rd_q, e);
  endtask : rc

  task automatic t_events;
    cmp_one_output_i <= 1'b1;
    cyc(8);
    rc(a_req, 32'h20, "cmp one");
    cmp_two_output_i <= 1'b1;
    nv_write_busy_i <= 1'b1;
    cyc(8);
    rc(a_req, 32'h60, "write pending");
    nv_write_busy_i <= 1'b0;
    osc_fail_i <= 1'b1;
    cyc(8);
    rc(a_req, 32'hF0, "all flags");
    rc(a_irq, 32'hF0, "irq status");
    rc(a_irq, 32'h0, "irq read clear");
    @(negedge clk_i);
    chk("irq masked", irq_o, 1'b0);
    wr(a_req, 32'hFF, 2'h0);
    rc(a_req, 32'hF0, "low nibble");
    wr(a_req, 32'h0, 2'h0);
    rc(a_req, 32'h0, "sw clear");
    wr(a_msk, 32'hF0, 2'h0);
    cmp_one_output_i <= 1'b0;
    cyc(8);
    wr(a_msk, 32'h0, 2'h0);
    @(negedge clk_i);
    chk("irq off", irq_o, 1'b0);
    wr(a_msk, 32'h20, 2'h0);
    @(negedge clk_i);
    chk("irq on", irq_o, 1'b1);
    rc(a_msk, 32'h20, "mask read");
    rc(a_irq, 32'h20, "irq one");
    @(negedge clk_i);
    chk("irq gone", irq_o, 1'b0);
    $display("t_events done");
  endtask : t_events

  task automatic t_pwr;
    wr(a_pwr, 32'hFF, 2'h0);
    rc(a_pwr, 32'h33, "pwr ones");
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_i);
      brownout_config_mode_i <= m[1:0];
      cyc(1);
      @(negedge clk_i);
      chk("bod en", brownout_detect_en_o, m == 1 ? 1'b1 : m[1]);
    end
    chk("ulp on", ultra_low_power_wake_en_o, 1'b1);
    wr(a_pwr, 32'h0, 2'h0);
    brownout_config_mode_i <= 2'h1;
    cyc(2);
    @(negedge clk_i);
    chk("bod off", brownout_detect_en_o, 1'b0);
    chk("ulp off", ultra_low_power_wake_en_o, 1'b0);
    $display("t_pwr done");
  endtask : t_pwr

  task automatic t_cause;
    wr(a_pwr, 32'h33, 2'h0);
    bor_event_i <= 1'b1;
    cyc(8);
    rc(a_pwr, 32'h32, "bor cause");
    por_event_i <= 1'b1;
    wdt_event_i <= 1'b1;
    pin_reset_event_i <= 1'b1;
    cyc(8);
    rc(a_pwr, 32'h10, "por cause");
    rc(a_cau, 32'h3, "wdt pin cause");
    wr(a_cau, 32'h3, 2'h0);
    rc(a_cau, 32'h0, "cause clear");
    rc(a_irq, 32'h0F, "reset irqs");
    wr(a_pwr, 32'h3, 2'h0);
    rc(a_pwr, 32'h3, "sw sets");
    s_axi_wstrb <= 4'hE;
    wr(a_pwr, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rc(a_pwr, 32'h3, "no strobe");
    wr(12'h0F0, 32'hFF, 2'h2);
    rc(12'h0F0, 32'h0, "unmapped");
    chk("rresp", rsp_q, 2'h2);
    $display("t_cause done");
  endtask : t_cause

  initial
  begin
    cyc(6);
    rst_i <= 1'b0;
    rc(a_req, 32'h0, "req reset");
    rc(a_pwr, 32'h10, "pwr reset");
    t_events();
    t_pwr();
    t_cause();
    report_and_stop();
  end
endmodule : tb
